// file: rtl/nvsr_pkg.sv
// What this block does
// - every mode command opens with five reads of the fixed prefix addresses, in order.
// - no other access may fall between the six sequence reads.
// - write strobe stays high through all six sequence reads.
// - with nothing pending, the first access of each command waits until the requester releases the line.
// - after changing the automatic save setting a save must follow.
package nvsr_pkg;
  // avalon word indices of the controller registers
  localparam logic [2:0]  REG_CTRL   = 3'h0;
  localparam logic [2:0]  REG_ADDR   = 3'h1;
  localparam logic [2:0]  REG_WDATA  = 3'h2;
  localparam logic [2:0]  REG_RDATA  = 3'h3;
  localparam logic [2:0]  REG_STATUS = 3'h4;
  // ctrl command field
  localparam int          CMD_LSB    = 0;
  localparam int          CMD_W      = 3;
  // status bit positions
  localparam int          ST_BUSY    = 0;
  localparam int          ST_LINE_LO = 1;
  localparam int          ST_PEND    = 2;
  localparam int          ST_AUTO    = 3;
  localparam logic        AUTO_RST   = 1'b1;
  localparam logic [16:0] ADDR_RST   = 17'h00000;
  localparam logic [15:0] DATA_RST   = 16'h0000;
  typedef enum logic [2:0] {
    NVSR_CMD_READ    = 3'h0,
    NVSR_CMD_WRITE   = 3'h1,
    NVSR_CMD_SAVE    = 3'h2,
    NVSR_CMD_RESTORE = 3'h3,
    NVSR_CMD_AUTOOFF = 3'h4,
    NVSR_CMD_AUTOON  = 3'h5,
    NVSR_CMD_HWSAVE  = 3'h6,
    NVSR_CMD_NONE    = 3'h7
  } nvsr_cmd_t;
  // sequence addresses
  localparam logic [16:0] SEQ_A0     = 17'h04e38;
  localparam logic [16:0] SEQ_A1     = 17'h0b1c7;
  localparam logic [16:0] SEQ_A2     = 17'h083e0;
  localparam logic [16:0] SEQ_A3     = 17'h07c1f;
  localparam logic [16:0] SEQ_A4     = 17'h0703f;
  localparam logic [16:0] SEQ_SAVE   = 17'h08fc0;
  localparam logic [16:0] SEQ_REST   = 17'h04c63;
  localparam logic [16:0] SEQ_AOFF   = 17'h08b45;
  localparam logic [16:0] SEQ_AON    = 17'h04b46;
  localparam logic [2:0]  SEQ_LAST   = 3'h5;
  // timing
  localparam int          CLK_NS     = 10;
  localparam int          ACCESS_NS  = 45;
  localparam int          ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SETTLE_NS  = 200;
  localparam int          SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PULL_NS    = 1000;
  localparam int          PULL_CYC   = (PULL_NS + CLK_NS - 1) / CLK_NS;
endpackage

// file: rtl/nvsr_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface nvsr_cyc_if;
  logic        req;
  logic        wr;
  logic [16:0] addr;
  logic [15:0] wdata;
  logic        done;
  logic [15:0] rdata;
  modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng  (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// file: rtl/nvsr_sram_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// one select-controlled sram access, held for a fixed count of cycles
module nvsr_sram_cycle #(
  parameter int ACC_CYC = nvsr_pkg::ACCESS_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  nvsr_cyc_if.eng          cyc,
  output logic [16:0]      sram_addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe_n,
  input  wire logic [15:0] dq_in,
  output logic             chip_select_n,
  output logic             output_strobe_n,
  output logic             write_strobe_n,
  output logic             upper_byte_select_n,
  output logic             lower_byte_select_n
);
  logic        active_ff;
  logic        wr_ff;
  logic        done_ff;
  logic [7:0]  cnt_ff;
  logic [15:0] rdata_ff;
  logic [16:0] addr_ff;
  logic [15:0] wdata_ff;
  wire         start = cyc.req & ~active_ff & ~done_ff;
  wire         last  = active_ff & (cnt_ff == 8'(ACC_CYC - 1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active_ff <= 1'b0;
      wr_ff     <= 1'b0;
      done_ff   <= 1'b0;
      cnt_ff    <= 8'h00;
      rdata_ff  <= nvsr_pkg::DATA_RST;
      addr_ff   <= nvsr_pkg::ADDR_RST;
      wdata_ff  <= nvsr_pkg::DATA_RST;
    end else begin
      done_ff <= last;
      if (start) begin
        active_ff <= 1'b1;
        wr_ff     <= cyc.wr;
        addr_ff   <= cyc.addr;
        wdata_ff  <= cyc.wdata;
        cnt_ff    <= 8'h00;
      end else if (last) begin
        active_ff <= 1'b0;
        wr_ff     <= 1'b0;
        if (!wr_ff)
          rdata_ff <= dq_in;
      end else if (active_ff) begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  assign cyc.done            = done_ff;
  assign cyc.rdata           = rdata_ff;
  assign sram_addr           = addr_ff;
  assign dq_out              = wdata_ff;
  assign dq_oe_n             = ~wr_ff;
  assign chip_select_n       = ~active_ff;
  assign output_strobe_n     = ~(active_ff & ~wr_ff);
  assign write_strobe_n      = ~wr_ff;
  assign upper_byte_select_n = ~active_ff;
  assign lower_byte_select_n = ~active_ff;
endmodule
`default_nettype wire

// file: rtl/nvsr_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module nvsr_host_ctrl #(
  parameter int ACC_CYC    = nvsr_pkg::ACCESS_CYC,
  parameter int SETTLE_CYC = nvsr_pkg::SETTLE_CYC,
  parameter int PULL_CYC   = nvsr_pkg::PULL_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [16:0]      sram_addr,
  output logic [15:0]      dq_out,
  output logic             dq_oe_n,
  input  wire logic [15:0] dq_in,
  output logic             chip_select_n,
  output logic             output_strobe_n,
  output logic             write_strobe_n,
  output logic             upper_byte_select_n,
  output logic             lower_byte_select_n,
  input  wire logic        save_busy_request_n_in,
  output logic             save_busy_request_n_out,
  output logic             save_busy_request_n_oe_n
);
  typedef enum logic [2:0] {
    NVSR_IDLE   = 3'b000,
    NVSR_LINE   = 3'b001,
    NVSR_ACC    = 3'b011,
    NVSR_SEQ    = 3'b010,
    NVSR_SETTLE = 3'b110,
    NVSR_DONE   = 3'b111,
    NVSR_PULL   = 3'b101,
    NVSR_RELSE  = 3'b100
  } nvsr_state_t;

  nvsr_cyc_if cyc ();

  nvsr_state_t state_ff;
  nvsr_state_t nxt_state;
  nvsr_pkg::nvsr_cmd_t cmd_ff;
  logic [2:0]  step_ff;
  logic [15:0] cnt_ff;
  logic        line_s1_ff;
  logic        line_s2_ff;
  logic        pull_ff;
  logic        follow_ff;
  logic        pend_ff;
  logic        auto_ff;
  logic        ack_ff;
  logic [31:0] rd_ff;
  logic [16:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;

  // device address for each step of a mode sequence
  function automatic logic [16:0] seq_addr(input logic [2:0] step, input nvsr_pkg::nvsr_cmd_t cmd);
    logic [16:0] a;
    a = nvsr_pkg::SEQ_A0;
    unique case (step)
      3'h0: a = nvsr_pkg::SEQ_A0;
      3'h1: a = nvsr_pkg::SEQ_A1;
      3'h2: a = nvsr_pkg::SEQ_A2;
      3'h3: a = nvsr_pkg::SEQ_A3;
      3'h4: a = nvsr_pkg::SEQ_A4;
      default: begin
        if (cmd == nvsr_pkg::NVSR_CMD_RESTORE)
          a = nvsr_pkg::SEQ_REST;
        else if (cmd == nvsr_pkg::NVSR_CMD_AUTOOFF)
          a = nvsr_pkg::SEQ_AOFF;
        else if (cmd == nvsr_pkg::NVSR_CMD_AUTOON)
          a = nvsr_pkg::SEQ_AON;
        else
          a = nvsr_pkg::SEQ_SAVE;
      end
    endcase
    return a;
  endfunction

  // avalon slave decode
  wire        bus_req   = avs_read | avs_write;
  wire        bus_take  = bus_req & ~ack_ff;
  wire        wr_take   = avs_write & ~ack_ff;
  wire        is_idle   = (state_ff == NVSR_IDLE);
  wire        line_high = line_s2_ff;
  wire [2:0]  wcmd      = avs_writedata[nvsr_pkg::CMD_LSB +: nvsr_pkg::CMD_W];
  wire        cmd_go    = wr_take & (avs_address == nvsr_pkg::REG_CTRL) & is_idle
                          & (wcmd != nvsr_pkg::NVSR_CMD_NONE);
  wire        is_seq    = (cmd_ff != nvsr_pkg::NVSR_CMD_READ) & (cmd_ff != nvsr_pkg::NVSR_CMD_WRITE)
                          & (cmd_ff != nvsr_pkg::NVSR_CMD_HWSAVE);
  wire        sets_auto = (cmd_ff == nvsr_pkg::NVSR_CMD_AUTOOFF) | (cmd_ff == nvsr_pkg::NVSR_CMD_AUTOON);
  wire        seq_end   = (state_ff == NVSR_SEQ) & cyc.done & (step_ff == nvsr_pkg::SEQ_LAST);
  wire        acc_wr    = (state_ff == NVSR_ACC) & (cmd_ff == nvsr_pkg::NVSR_CMD_WRITE);
  wire        cnt_zero  = (cnt_ff == 16'h0000);
  wire [31:0] status    = {28'h0000000, auto_ff, pend_ff, ~line_high, ~is_idle};

  wire [31:0] rd_mux =
    (avs_address == nvsr_pkg::REG_CTRL)   ? {29'h00000000, cmd_ff} :
    (avs_address == nvsr_pkg::REG_ADDR)   ? {15'h0000, addr_ff} :
    (avs_address == nvsr_pkg::REG_WDATA)  ? {16'h0000, wdata_ff} :
    (avs_address == nvsr_pkg::REG_RDATA)  ? {16'h0000, rdata_ff} :
    (avs_address == nvsr_pkg::REG_STATUS) ? status : 32'h00000000;

  // sequence reads go out back to back, never a write between them
  assign cyc.req   = (state_ff == NVSR_ACC) | (state_ff == NVSR_SEQ);
  assign cyc.wr    = acc_wr & line_high;
  assign cyc.addr  = (state_ff == NVSR_SEQ) ? seq_addr(step_ff, cmd_ff) : addr_ff;
  assign cyc.wdata = wdata_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      NVSR_IDLE:
        if (cmd_go)
          nxt_state = (wcmd == nvsr_pkg::NVSR_CMD_HWSAVE) ? NVSR_PULL : NVSR_LINE;
      // every read, write and sequence command waits for the busy line high before its first access: power-up restore, saves, foreign requests
      NVSR_LINE:
        if (line_high)
          nxt_state = is_seq ? NVSR_SEQ : NVSR_ACC;
      NVSR_ACC:
        if (cyc.done)
          nxt_state = NVSR_IDLE;
      NVSR_SEQ:
        if (seq_end)
          nxt_state = sets_auto ? (follow_ff ? NVSR_LINE : NVSR_IDLE) : NVSR_SETTLE;
      NVSR_SETTLE:
        if (cnt_zero)
          nxt_state = NVSR_DONE;
      NVSR_DONE:
        if (line_high)
          nxt_state = NVSR_IDLE;
      NVSR_PULL:
        if (cnt_zero)
          nxt_state = NVSR_RELSE;
      NVSR_RELSE:
        if (cnt_zero)
          nxt_state = NVSR_DONE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_s1_ff <= 1'b1;
      line_s2_ff <= 1'b1;
    end else begin
      line_s1_ff <= save_busy_request_n_in;
      line_s2_ff <= line_s1_ff;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      state_ff <= NVSR_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ff    <= nvsr_pkg::NVSR_CMD_NONE;
      follow_ff <= 1'b0;
    end else if (cmd_go) begin
      cmd_ff    <= nvsr_pkg::nvsr_cmd_t'(wcmd);
      follow_ff <= (wcmd == nvsr_pkg::NVSR_CMD_AUTOOFF) | (wcmd == nvsr_pkg::NVSR_CMD_AUTOON);
    end else if (seq_end & sets_auto & follow_ff) begin
      cmd_ff    <= nvsr_pkg::NVSR_CMD_SAVE;
      follow_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      step_ff <= 3'h0;
    else if (state_ff != NVSR_SEQ)
      step_ff <= 3'h0;
    else if (cyc.done)
      step_ff <= step_ff + 3'h1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      cnt_ff <= 16'h0000;
    else if (seq_end)
      cnt_ff <= 16'(SETTLE_CYC - 1);
    else if (cmd_go)
      cnt_ff <= 16'(PULL_CYC - 1);
    else if ((state_ff == NVSR_PULL) & cnt_zero)
      cnt_ff <= 16'(SETTLE_CYC - 1);
    else if (!cnt_zero)
      cnt_ff <= cnt_ff - 16'h0001;
  end

  // request line pulled low for the hold time, then left to the device
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      pull_ff <= 1'b0;
    else
      pull_ff <= (nxt_state == NVSR_PULL);
  end

  // host copy of the device's pending-write and automatic-save state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_ff <= 1'b0;
      auto_ff <= nvsr_pkg::AUTO_RST;
    end else begin
      if (acc_wr & cyc.done)
        pend_ff <= 1'b1;
      else if ((state_ff == NVSR_DONE) & line_high)
        pend_ff <= 1'b0;
      if (seq_end & (cmd_ff == nvsr_pkg::NVSR_CMD_AUTOOFF))
        auto_ff <= 1'b0;
      else if (seq_end & (cmd_ff == nvsr_pkg::NVSR_CMD_AUTOON))
        auto_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff  <= nvsr_pkg::ADDR_RST;
      wdata_ff <= nvsr_pkg::DATA_RST;
    end else if (wr_take & is_idle) begin
      if (avs_address == nvsr_pkg::REG_ADDR)
        addr_ff <= avs_writedata[16:0];
      if (avs_address == nvsr_pkg::REG_WDATA)
        wdata_ff <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      rdata_ff <= nvsr_pkg::DATA_RST;
    else if ((state_ff == NVSR_ACC) & cyc.done & (cmd_ff == nvsr_pkg::NVSR_CMD_READ))
      rdata_ff <= cyc.rdata;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      rd_ff  <= 32'h00000000;
    end else begin
      ack_ff <= bus_take;
      if (avs_read & ~ack_ff)
        rd_ff <= rd_mux;
    end
  end

  assign avs_waitrequest          = bus_req & ~ack_ff;
  assign avs_readdata             = rd_ff;
  assign save_busy_request_n_out  = 1'b0;
  assign save_busy_request_n_oe_n = ~pull_ff;

  nvsr_sram_cycle #(
    .ACC_CYC (ACC_CYC)
  ) u_cycle (
    .clk                 (clk),
    .nrst                (nrst),
    .cyc                 (cyc.eng),
    .sram_addr           (sram_addr),
    .dq_out              (dq_out),
    .dq_oe_n             (dq_oe_n),
    .dq_in               (dq_in),
    .chip_select_n       (chip_select_n),
    .output_strobe_n     (output_strobe_n),
    .write_strobe_n      (write_strobe_n),
    .upper_byte_select_n (upper_byte_select_n),
    .lower_byte_select_n (lower_byte_select_n)
  );
endmodule
`default_nettype wire

// file: sim/nvsr_host_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module nvsr_chk #(
  parameter int ACC_CYC  = 5,
  parameter int PULL_CYC = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic dq_oe_n,
  input wire logic chip_select_n,
  input wire logic output_strobe_n,
  input wire logic write_strobe_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  input wire logic save_busy_request_n_in,
  input wire logic save_busy_request_n_oe_n
);
  logic [7:0] ce_cnt_ff;
  logic [7:0] pull_cnt_ff;
  // length of the current select-low and pull-low runs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ce_cnt_ff   <= 8'h00;
      pull_cnt_ff <= 8'h00;
    end else begin
      ce_cnt_ff   <= chip_select_n ? 8'h00 : ce_cnt_ff + 8'h01;
      pull_cnt_ff <= save_busy_request_n_oe_n ? 8'h00 : pull_cnt_ff + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past the first cycle");
  chk_acc_len: assert property ($rose(chip_select_n) |-> ce_cnt_ff == ACC_CYC)
    else $error("access length wrong");
  chk_acc_gap: assert property ($rose(chip_select_n) |=> chip_select_n)
    else $error("no idle cycle between accesses");
  chk_pull_len: assert property ($rose(save_busy_request_n_oe_n) |-> pull_cnt_ff == PULL_CYC)
    else $error("request pull length wrong");
  chk_read_we_high: assert property (!output_strobe_n |-> write_strobe_n && dq_oe_n)
    else $error("write strobe low during read");
  chk_write_strobes: assert property (!write_strobe_n |-> !chip_select_n && !dq_oe_n && output_strobe_n)
    else $error("write strobes inconsistent");
  chk_start_line_hi: assert property ($fell(chip_select_n) |-> save_busy_request_n_in)
    else $error("access started while line low");
  chk_pull_no_acc: assert property (!save_busy_request_n_oe_n |-> chip_select_n)
    else $error("access while pulling line");
  chk_both_bytes: assert property (!chip_select_n |-> !upper_byte_select_n && !lower_byte_select_n)
    else $error("byte selects not both low");
  cov_pull: cover property ($rose(save_busy_request_n_oe_n));
  cov_write: cover property ($fell(write_strobe_n));
  cov_line_low: cover property ($fell(save_busy_request_n_in));
endmodule
bind nvsr_host_ctrl nvsr_chk #(.ACC_CYC(ACC_CYC), .PULL_CYC(PULL_CYC)) u_chk (
  .clk(clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .dq_oe_n(dq_oe_n), .chip_select_n(chip_select_n), .output_strobe_n(output_strobe_n),
  .write_strobe_n(write_strobe_n), .upper_byte_select_n(upper_byte_select_n),
  .lower_byte_select_n(lower_byte_select_n), .save_busy_request_n_in(save_busy_request_n_in),
  .save_busy_request_n_oe_n(save_busy_request_n_oe_n));
`default_nettype wire

// file: sim/nvsr_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvsr_dev_model #(
  parameter int SAVE_CYC  = 40,
  parameter int REST_CYC  = 30,
  parameter int PUR_CYC   = 25,
  parameter int DEFER_CYC = 4
) (
  input  wire logic        clk,
  input  wire logic        supply_ok,
  input  wire logic [16:0] sram_addr,
  input  wire logic [15:0] dq_out,
  input  wire logic        chip_select_n,
  input  wire logic        output_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        line_n,
  output logic      [15:0] dq_in,
  output logic             dev_low
);
  logic [15:0] mem [256];
  logic [15:0] nv [256];
  logic [16:0] pre [5] = '{nvsr_pkg::SEQ_A0, nvsr_pkg::SEQ_A1, nvsr_pkg::SEQ_A2,
                           nvsr_pkg::SEQ_A3, nvsr_pkg::SEQ_A4};
  logic        auto_ff = 1'b1;
  logic        pend_ff = 1'b0;
  logic        ce_ff = 1'b1;
  logic        sup_ff = 1'b1;
  logic [15:0] last_ff = 16'h0000;
  int          step_ff = 0;
  int          hold_ff = PUR_CYC;
  int          defer_ff = 0;
  int          saves_ff = 0;
  wire   [7:0] idx = sram_addr[7:0];
  // undriven data lines flip every cycle rather than keep the last value
  assign dq_in = (!chip_select_n && !output_strobe_n && write_strobe_n && line_n) ? mem[idx] : ~last_ff;
  assign dev_low = hold_ff > 0;
  initial begin
    foreach (mem[i]) begin
      mem[i] = 16'h0000;
      nv[i] = 16'h0000;
    end
  end
  function automatic logic hit(input logic [16:0] a, input logic [16:0] b);
    return a[14:2] == b[14:2];
  endfunction
  task save_now;
    foreach (mem[i]) nv[i] <= mem[i];
    saves_ff <= saves_ff + 1;
    pend_ff <= 1'b0;
    hold_ff <= SAVE_CYC;
  endtask
  task restore_now(input int n);
    foreach (mem[i]) mem[i] <= nv[i];
    pend_ff <= 1'b0;
    hold_ff <= n;
  endtask
  always @(posedge clk) begin
    last_ff <= dq_in;
    ce_ff <= chip_select_n;
    sup_ff <= supply_ok;
    if (hold_ff > 0) hold_ff <= hold_ff - 1;
    if (defer_ff > 0) defer_ff <= defer_ff - 1;
    if (defer_ff == 1) save_now();
    if (!line_n && hold_ff == 0 && defer_ff == 0 && pend_ff) defer_ff <= DEFER_CYC;
    if (!chip_select_n && !write_strobe_n && line_n && hold_ff == 0) begin
      mem[idx] <= dq_out;
      pend_ff <= 1'b1;
      step_ff <= 0;
    end
    if (ce_ff && !chip_select_n && write_strobe_n && line_n) begin
      if (step_ff == 5) begin
        step_ff <= 0;
        if (hit(sram_addr, nvsr_pkg::SEQ_SAVE)) save_now();
        if (hit(sram_addr, nvsr_pkg::SEQ_REST)) restore_now(REST_CYC);
        if (hit(sram_addr, nvsr_pkg::SEQ_AOFF)) auto_ff <= 1'b0;
        if (hit(sram_addr, nvsr_pkg::SEQ_AON)) auto_ff <= 1'b1;
      end else begin
        step_ff <= hit(sram_addr, pre[step_ff]) ? step_ff + 1 : (hit(sram_addr, pre[0]) ? 1 : 0);
      end
    end
    if (sup_ff && !supply_ok && auto_ff && pend_ff) save_now();
    if (!sup_ff && supply_ok) restore_now(PUR_CYC);
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic        supply_ok = 1'b1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [16:0] sram_addr;
  logic [15:0] dq_out;
  logic [15:0] dq_in;
  logic        dq_oe_n;
  logic        ce_n;
  logic        oe_n;
  logic        we_n;
  logic        busy_out;
  logic        busy_oe_n;
  logic        dev_low;
  int          err_total = 0;
  int          num_checks = 0;
  // open-drain line: host pulls low when enabled with its out value low, device pulls low, else pull-up
  wire         line_n = ((!busy_oe_n && !busy_out) || dev_low) ? 1'b0 : 1'b1;
  always #5 clk = ~clk;
  // settle longer than the model's defer so a pin-requested save is seen before the wait ends
  nvsr_host_ctrl #(.ACC_CYC(5), .SETTLE_CYC(6), .PULL_CYC(3)) dut (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sram_addr(sram_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in), .chip_select_n(ce_n),
    .output_strobe_n(oe_n), .write_strobe_n(we_n), .upper_byte_select_n(), .lower_byte_select_n(),
    .save_busy_request_n_in(line_n), .save_busy_request_n_out(busy_out),
    .save_busy_request_n_oe_n(busy_oe_n));
  nvsr_dev_model dev (
    .clk(clk), .supply_ok(supply_ok), .sram_addr(sram_addr), .dq_out(dq_out), .chip_select_n(ce_n),
    .output_strobe_n(oe_n), .write_strobe_n(we_n), .line_n(line_n), .dq_in(dq_in), .dev_low(dev_low));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until the edge that samples waitrequest low; data taken at that edge
  task automatic acc(input logic [2:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // issue one command, wait for idle, then compare the device save count
  task automatic op(input nvsr_pkg::nvsr_cmd_t c, input logic [16:0] a, input logic [15:0] d, input int sv);
    logic [31:0] s;
    acc(nvsr_pkg::REG_ADDR, 1'b1, {15'h0000, a}, s);
    acc(nvsr_pkg::REG_WDATA, 1'b1, {16'h0000, d}, s);
    acc(nvsr_pkg::REG_CTRL, 1'b1, {29'h00000000, c}, s);
    s = 32'h00000001;
    while (s[nvsr_pkg::ST_BUSY] !== 1'b0)
      acc(nvsr_pkg::REG_STATUS, 1'b0, 32'h00000000, s);
    chk("saves", sv, dev.saves_ff);
  endtask
  task automatic power_cycle;
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (10) @(posedge clk);
    supply_ok <= 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", err_total, num_checks);
    if (err_total == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    logic [31:0] r;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    acc(nvsr_pkg::REG_CTRL, 1'b0, 32'h00000000, r);
    chk("ctrl", 32'h00000007, r);
    acc(nvsr_pkg::REG_STATUS, 1'b0, 32'h00000000, r);
    chk("auto", 32'h00000001, 32'(r[nvsr_pkg::ST_AUTO]));
    acc(3'h5, 1'b0, 32'h00000000, r);
    chk("unmapped", 32'h00000000, r);
    op(nvsr_pkg::NVSR_CMD_WRITE, 17'h00010, 16'ha5a5, 0);
    chk("mem", 32'h0000a5a5, 32'(dev.mem[8'h10]));
    acc(nvsr_pkg::REG_STATUS, 1'b0, 32'h00000000, r);
    chk("pend", 32'h00000001, 32'(r[nvsr_pkg::ST_PEND]));
    op(nvsr_pkg::NVSR_CMD_READ, 17'h00010, 16'h0000, 0);
    acc(nvsr_pkg::REG_RDATA, 1'b0, 32'h00000000, r);
    chk("rdata", 32'h0000a5a5, r);
    op(nvsr_pkg::NVSR_CMD_SAVE, 17'h00000, 16'h0000, 1);
    chk("nv", 32'h0000a5a5, 32'(dev.nv[8'h10]));
    op(nvsr_pkg::NVSR_CMD_SAVE, 17'h00000, 16'h0000, 2);
    op(nvsr_pkg::NVSR_CMD_HWSAVE, 17'h00000, 16'h0000, 2);
    op(nvsr_pkg::NVSR_CMD_WRITE, 17'h00010, 16'h1234, 2);
    op(nvsr_pkg::NVSR_CMD_HWSAVE, 17'h00000, 16'h0000, 3);
    op(nvsr_pkg::NVSR_CMD_WRITE, 17'h00010, 16'h5678, 3);
    op(nvsr_pkg::NVSR_CMD_RESTORE, 17'h00000, 16'h0000, 3);
    op(nvsr_pkg::NVSR_CMD_READ, 17'h00010, 16'h0000, 3);
    acc(nvsr_pkg::REG_RDATA, 1'b0, 32'h00000000, r);
    chk("restored", 32'h00001234, r);
    op(nvsr_pkg::NVSR_CMD_AUTOOFF, 17'h00000, 16'h0000, 4);
    chk("auto_off", 32'h00000000, 32'(dev.auto_ff));
    op(nvsr_pkg::NVSR_CMD_WRITE, 17'h00010, 16'h9999, 4);
    power_cycle();
    op(nvsr_pkg::NVSR_CMD_AUTOON, 17'h00000, 16'h0000, 5);
    chk("auto_on", 32'h00000001, 32'(dev.auto_ff));
    op(nvsr_pkg::NVSR_CMD_WRITE, 17'h00010, 16'h9999, 5);
    power_cycle();
    op(nvsr_pkg::NVSR_CMD_READ, 17'h00010, 16'h0000, 6);
    acc(nvsr_pkg::REG_RDATA, 1'b0, 32'h00000000, r);
    chk("powerup", 32'h00009999, r);
    tally_and_finish();
  end
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
